// ---- dv/pag_timer_model.sv ----
// behavioural pwm timer feeding the qualifier
`timescale 1ns/1ps
`default_nettype none
module pag_timer_model (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_run,
   input wire logic [1:0] i_mode,
   input wire logic [15:0] i_period,
   output logic [15:0] o_count,
   output logic o_dir_up,
   output logic o_zero_match,
   output logic o_period_match
);
   // ====
   // counter: 0 up, 1 down, else up-down
   logic up;
   always @(posedge i_sys_clk) begin
      if (i_reset || !i_run) begin
         o_count <= 16'h0000;
         up <= 1'b1;
      end else if (i_mode == 2'h0) begin
         o_count <= (o_count == i_period) ? 16'h0000
                                          : o_count + 16'h0001;
      end else if (i_mode == 2'h1) begin
         o_count <= (o_count == 16'h0000) ? i_period
                                          : o_count - 16'h0001;
      end else if (up) begin
         o_count <= o_count + 16'h0001;
         up <= (o_count + 16'h0001 != i_period);
      end else begin
         o_count <= o_count - 16'h0001;
         up <= (o_count == 16'h0001);
      end
   end
   assign o_dir_up = (i_mode == 2'h0) | (i_mode[1] & up);
   assign o_zero_match = i_run && o_count == 16'h0000;
   assign o_period_match = i_run && o_count == i_period;
endmodule // pag_timer_model
`default_nettype wire

// ---- dv/pag_top_sva.sv ----
// assertion checker for the pwm action qualifier
`timescale 1ns/1ps
`default_nettype none
`include "pag_map.vh"
module pag_top_sva (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic o_pready,
   input wire logic [15:0] i_timer_count,
   input wire logic i_timer_dir_up,
   input wire logic [15:0] i_timer_period,
   input wire logic i_zero_match,
   input wire logic i_period_match,
   input wire logic [2:0] i_fault_event,
   input wire logic [2:0] i_sync_source,
   input wire logic o_output_a,
   input wire logic o_output_b,
   input wire logic [11:0] o_events
);
   // ====
   // cycles since the last force write
   logic [2:0] age;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset)
         age <= 3'h7;
      else if (i_psel && i_penable && i_pwrite && o_pready &&
            i_paddr == `PAG_OFS_FORCE)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // ====
   // properties
   AST_ZERO: assert property (!$past(i_reset) |->
      o_events[0] == $past(i_zero_match && i_timer_dir_up) &&
      o_events[6] == $past(i_zero_match && !i_timer_dir_up))
      else $error("zero match event wrong");
   AST_PER: assert property (!$past(i_reset) |->
      o_events[1] == $past(i_period_match && i_timer_dir_up) &&
      o_events[7] == $past(i_period_match && !i_timer_dir_up))
      else $error("period match event wrong");
   AST_CMP_UP: assert property (o_events[2] || o_events[3] |->
      $past(i_timer_dir_up && i_timer_count <= i_timer_period))
      else $error("up compare event without cause");
   AST_CMP_DN: assert property (o_events[8] || o_events[9] |->
      $past(!i_timer_dir_up && i_timer_count <= i_timer_period))
      else $error("down compare event without cause");
   AST_DIR: assert property (!(|o_events[5:0] && |o_events[11:6]))
      else $error("up and down events together");
   AST_TRIG: assert property (|{o_events[11:10], o_events[5:4]} |->
      $past(|{i_fault_event, i_sync_source}))
      else $error("trigger event without source");
   AST_RST_LOW: assert property ($past(i_reset) |->
      !o_output_a && !o_output_b && o_events == 12'h000)
      else $error("outputs not low after reset");
   AST_QUIET: assert property (!$past(i_reset) &&
      ($changed(o_output_a) || $changed(o_output_b)) |->
      o_events != 12'h000 || $past(o_events) != 12'h000 || age < 3'h4)
      else $error("output changed without event");
   AST_READY: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready after setup");
   cover property (o_events[2]);
   cover property (o_events[8]);
   cover property ($rose(o_output_a));
endmodule // pag_top_sva
bind pag_top pag_top_sva pag_top_sva_inst (.i_sys_clk, .i_reset,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready, .i_timer_count,
   .i_timer_dir_up, .i_timer_period, .i_zero_match, .i_period_match,
   .i_fault_event, .i_sync_source, .o_output_a, .o_output_b, .o_events);
`default_nettype wire

// ---- dv/pag_top_tb.sv ----
// self-checking testbench for the pwm action qualifier
`timescale 1ns/1ps
`default_nettype none
`include "pag_map.vh"
module pag_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic run = 1'b0;
   logic [1:0] mode = 2'h2;
   logic [15:0] per = 16'h0008;
   logic [2:0] fault = 3'h0;
   logic [2:0] sync = 3'h0;
   logic [31:0] prdata;
   logic pready, pslverr, out_a, out_b, dir, zm, pm;
   logic [11:0] events;
   logic [15:0] count;
   logic [31:0] exp_q[$];
   int n_mismatch = 0;
   int num_checks = 0;
   int w;
   int a;
   always #12.5 clk = ~clk;
   pag_top pag_top_inst (.i_sys_clk(clk), .i_reset(rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_timer_count(count), .i_timer_dir_up(dir),
      .i_timer_period(per), .i_zero_match(zm), .i_period_match(pm),
      .i_sync_event(1'b0), .i_fault_event(fault), .i_sync_source(sync),
      .o_output_a(out_a), .o_output_b(out_b), .o_events(events));
   pag_timer_model pag_timer_model_inst (.i_sys_clk(clk), .i_reset(rst),
      .i_run(run), .i_mode(mode), .i_period(per), .o_count(count),
      .o_dir_up(dir), .o_zero_match(zm), .o_period_match(pm));
   // ====
   // tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      if (!wr)
         exp_q.push_back(d);
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         wrap_up;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // high time of one output in cycles, 0 if it never rises
   task meas(input logic b, output int hw);
      int n;
      hw = 0;
      n = 0;
      while ((b ? out_b : out_a) !== 1'b0 && n < 60) begin
         @(posedge clk);
         n++;
      end
      while ((b ? out_b : out_a) !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      while ((b ? out_b : out_a) === 1'b1 && hw < 90) begin
         @(posedge clk);
         hw++;
      end
   endtask
   // ====
   // read data and error monitor
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk(prdata, exp_q.pop_front());
      if (psel && penable && pready === 1'b1)
         chk({31'h0, pslverr}, {31'h0, paddr > 8'h18});
   end
   // ====
   // main sequence
   initial begin
      void'($urandom(60098));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, `PAG_OFS_CONFIG, `PAG_CFG_RESET);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      apb(1'b1, `PAG_OFS_CONFIG, 32'h0000_029F);
      apb(1'b1, `PAG_OFS_ACT_A, 32'h0000_0900);
      apb(1'b1, `PAG_OFS_ACT_B, 32'h0000_0200);
      fault <= 3'h2;
      sync <= 3'h4;
      @(posedge clk);
      fault <= 3'h0;
      sync <= 3'h0;
      @(posedge clk);
      apb(1'b0, `PAG_OFS_STATUS, 32'h0000_03C2);
      apb(1'b1, `PAG_OFS_FORCE, 32'h0000_0012);
      @(posedge clk);
      chk({31'h0, out_a}, 32'h0000_0001);
      @(posedge clk);
      chk({31'h0, out_a}, 32'h0000_0001);
      apb(1'b1, `PAG_OFS_FORCE, 32'h0000_0035);
      apb(1'b1, `PAG_OFS_ACT_A, 32'h0001_0020);
      apb(1'b1, `PAG_OFS_ACT_B, 32'h0000_4082);
      for (int i = 0; i < 4; i++) begin
         a = (i < 3) ? $urandom_range(7, 1) : 9;
         apb(1'b1, `PAG_OFS_STAMP_A, a);
         run <= 1'b1;
         meas(1'b0, w);
         chk(w, (a > 8) ? 0 : 2 * (8 - a));
         if (i == 0) begin
            meas(1'b1, w);
            chk(w, 32'h0000_0008);
         end
         run <= 1'b0;
         @(posedge clk);
      end
      apb(1'b1, `PAG_OFS_STAMP_A, 32'h0000_0000);
      apb(1'b1, `PAG_OFS_STAMP_B, 32'h0000_0004);
      apb(1'b1, `PAG_OFS_ACT_A, 32'h0004_0021);
      run <= 1'b1;
      meas(1'b0, w);
      chk(w, 32'h0000_000C);
      run <= 1'b0;
      @(posedge clk);
      apb(1'b1, `PAG_OFS_STAMP_A, 32'h0000_0008);
      apb(1'b1, `PAG_OFS_STAMP_B, 32'h0000_0002);
      apb(1'b1, `PAG_OFS_ACT_A, 32'h0002_4040);
      run <= 1'b1;
      meas(1'b0, w);
      chk(w, 32'h0000_000A);
      // sustained high on a, engaged at once, then released
      apb(1'b1, `PAG_OFS_FORCE, 32'h0000_0080);
      meas(1'b0, w);
      chk(w, 32'h0000_005A);
      apb(1'b1, `PAG_OFS_FORCE, 32'h0000_0000);
      meas(1'b0, w);
      chk(w, 32'h0000_000A);
      wrap_up;
   end
endmodule // pag_top_tb
`default_nettype wire

// ---- verilog/pag_action.v ----
// priority resolution and action for one output
`timescale 1ns/1ps
`default_nettype none
`include "pag_map.vh"
module pag_action (
   input wire [11:0] i_ev,
   input wire [23:0] i_act,
   input wire i_force,
   input wire [1:0] i_force_act,
   input wire i_level,
   output reg o_next
);
   reg [1:0] sel;

   function [1:0] pick;
      input [23:0] act;
      input integer idx;
      begin
         pick = act[idx*2 +: 2];
      end
   endfunction

   // ==================================================
   // up and down events never coincide, so one chain
   always @* begin
      sel = `PAG_ACT_NONE;
      if (i_force) begin
         sel = i_force_act;
      end else if (i_ev[`PAG_EV_UP]) begin
         sel = pick(i_act, `PAG_EV_UP);
      end else if (i_ev[`PAG_EV_DZ]) begin
         sel = pick(i_act, `PAG_EV_DZ);
      end else if (i_ev[`PAG_EV_UT0]) begin
         sel = pick(i_act, `PAG_EV_UT0);
      end else if (i_ev[`PAG_EV_DT0]) begin
         sel = pick(i_act, `PAG_EV_DT0);
      end else if (i_ev[`PAG_EV_UT1]) begin
         sel = pick(i_act, `PAG_EV_UT1);
      end else if (i_ev[`PAG_EV_DT1]) begin
         sel = pick(i_act, `PAG_EV_DT1);
      end else if (i_ev[`PAG_EV_UB]) begin
         sel = pick(i_act, `PAG_EV_UB);
      end else if (i_ev[`PAG_EV_DB]) begin
         sel = pick(i_act, `PAG_EV_DB);
      end else if (i_ev[`PAG_EV_UA]) begin
         sel = pick(i_act, `PAG_EV_UA);
      end else if (i_ev[`PAG_EV_DA]) begin
         sel = pick(i_act, `PAG_EV_DA);
      end else if (i_ev[`PAG_EV_UZ]) begin
         sel = pick(i_act, `PAG_EV_UZ);
      end else if (i_ev[`PAG_EV_DP]) begin
         sel = pick(i_act, `PAG_EV_DP);
      end
      case (sel)
         `PAG_ACT_LOW: o_next = 1'b0;
         `PAG_ACT_HIGH: o_next = 1'b1;
         `PAG_ACT_TOGGLE: o_next = ~i_level;
         default: o_next = i_level;
      endcase
   end
endmodule // pag_action
`default_nettype wire

// ---- verilog/pag_map.vh ----
// register map, field positions and codes of the pwm action qualifier
`ifndef PAG_MAP_VH
`define PAG_MAP_VH

// ==================================================
// register offsets (byte addresses)
`define PAG_OFS_STAMP_A 8'h00
`define PAG_OFS_STAMP_B 8'h04
`define PAG_OFS_CONFIG 8'h08
`define PAG_OFS_ACT_A 8'h0C
`define PAG_OFS_ACT_B 8'h10
`define PAG_OFS_FORCE 8'h14
`define PAG_OFS_STATUS 8'h18

// ==================================================
// config fields
`define PAG_CFG_STAMP_UPD 1:0
`define PAG_CFG_ACT_UPD 3:2
`define PAG_CFG_T0_SEL 6:4
`define PAG_CFG_T1_SEL 9:7
`define PAG_CFG_RESET 10'h3F3

// update methods
`define PAG_UPD_ZERO 2'h0
`define PAG_UPD_PERIOD 2'h1
`define PAG_UPD_SYNC 2'h2
`define PAG_UPD_NOW 2'h3

// ==================================================
// force fields
`define PAG_F_OS_A 1:0
`define PAG_F_OS_B 3:2
`define PAG_F_OS_A_GO 4
`define PAG_F_OS_B_GO 5
`define PAG_F_SU_A 7:6
`define PAG_F_SU_B 9:8
`define PAG_F_SU_TRIG 11:10

// ==================================================
// action codes
`define PAG_ACT_NONE 2'h0
`define PAG_ACT_LOW 2'h1
`define PAG_ACT_HIGH 2'h2
`define PAG_ACT_TOGGLE 2'h3

// ==================================================
// event bit indices
`define PAG_EV_UZ 0
`define PAG_EV_UP 1
`define PAG_EV_UA 2
`define PAG_EV_UB 3
`define PAG_EV_UT0 4
`define PAG_EV_UT1 5
`define PAG_EV_DZ 6
`define PAG_EV_DP 7
`define PAG_EV_DA 8
`define PAG_EV_DB 9
`define PAG_EV_DT0 10
`define PAG_EV_DT1 11

`endif

// ---- verilog/pag_shadow.v ----
// shadow and active copy of one register
`timescale 1ns/1ps
`default_nettype none
module pag_shadow #(
   parameter W = 16,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire i_sys_clk,
   input wire i_reset,
   input wire i_wr,
   input wire [W-1:0] i_wdata,
   input wire i_load,
   output reg [W-1:0] o_shadow,
   output reg [W-1:0] o_active
);
   // ==================================================
   // software side copy and timed transfer
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_shadow <= RST;
         o_active <= RST;
      end else begin
         if (i_wr) begin
            o_shadow <= i_wdata;
         end
         if (i_load) begin
            o_active <= o_shadow;
         end
      end
   end
endmodule // pag_shadow
`default_nettype wire

// ---- verilog/pag_top.v ----
// pwm action qualifier with apb register access
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pag_map.vh"
module pag_top (
   input wire i_sys_clk,
   input wire i_reset,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // from the pwm timer
   input wire [15:0] i_timer_count,
   input wire i_timer_dir_up,
   input wire [15:0] i_timer_period,
   input wire i_zero_match,
   input wire i_period_match,
   input wire i_sync_event,
   // trigger sources
   input wire [2:0] i_fault_event,
   input wire [2:0] i_sync_source,
   // to the dead-time generator
   output reg o_output_a,
   output reg o_output_b,
   output reg [11:0] o_events
);
   // ==================================================
   // declarations
   wire wr_en;
   wire [15:0] stamp_a_sh;
   wire [15:0] stamp_a;
   wire [15:0] stamp_b_sh;
   wire [15:0] stamp_b;
   wire [23:0] act_a_sh;
   wire [23:0] act_a;
   wire [23:0] act_b_sh;
   wire [23:0] act_b;
   reg [9:0] cfg;
   reg [11:0] force_cfg;
   reg os_go_a;
   reg os_go_b;
   reg [11:0] ev_flag;
   reg level_a;
   reg level_b;
   reg su_on_a;
   reg su_on_b;
   reg su_val_a;
   reg su_val_b;
   reg stamp_load;
   reg act_load;
   reg trig_zero;
   reg trig_one;
   reg su_trig;
   reg [11:0] ev;
   reg [31:0] rd_mux;
   reg rd_err;
   reg next_su_val_a;
   reg next_su_val_b;
   wire next_level_a;
   wire next_level_b;
   wire cmp_a;
   wire cmp_b;
   wire up;

   assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
   assign up = i_timer_dir_up;

   // ==================================================
   // shadowed stamps and action settings
   pag_shadow #(.W(16), .RST(16'h0000)) u_stamp_a (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_wr(wr_en && i_paddr == `PAG_OFS_STAMP_A),
      .i_wdata(i_pwdata[15:0]),
      .i_load(stamp_load),
      .o_shadow(stamp_a_sh),
      .o_active(stamp_a)
   );
   pag_shadow #(.W(16), .RST(16'h0000)) u_stamp_b (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_wr(wr_en && i_paddr == `PAG_OFS_STAMP_B),
      .i_wdata(i_pwdata[15:0]),
      .i_load(stamp_load),
      .o_shadow(stamp_b_sh),
      .o_active(stamp_b)
   );
   pag_shadow #(.W(24), .RST(24'h00_0000)) u_act_a (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_wr(wr_en && i_paddr == `PAG_OFS_ACT_A),
      .i_wdata(i_pwdata[23:0]),
      .i_load(act_load),
      .o_shadow(act_a_sh),
      .o_active(act_a)
   );
   pag_shadow #(.W(24), .RST(24'h00_0000)) u_act_b (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_wr(wr_en && i_paddr == `PAG_OFS_ACT_B),
      .i_wdata(i_pwdata[23:0]),
      .i_load(act_load),
      .o_shadow(act_b_sh),
      .o_active(act_b)
   );

   // ==================================================
   // shadow transfer moments
   always @* begin
      case (cfg[`PAG_CFG_STAMP_UPD])
         `PAG_UPD_ZERO: stamp_load = i_zero_match;
         `PAG_UPD_PERIOD: stamp_load = i_period_match;
         `PAG_UPD_SYNC: stamp_load = i_sync_event;
         default: stamp_load = 1'b1;
      endcase
      case (cfg[`PAG_CFG_ACT_UPD])
         `PAG_UPD_ZERO: act_load = i_zero_match;
         `PAG_UPD_PERIOD: act_load = i_period_match;
         `PAG_UPD_SYNC: act_load = i_sync_event;
         default: act_load = 1'b1;
      endcase
   end

   // ==================================================
   // trigger sources, chosen apart from the fault handler
   always @* begin
      case (cfg[`PAG_CFG_T0_SEL])
         3'h0, 3'h1, 3'h2:
            trig_zero = i_fault_event[cfg[5:4]];
         3'h3: trig_zero = i_sync_source[0];
         3'h4: trig_zero = i_sync_source[1];
         3'h5: trig_zero = i_sync_source[2];
         default: trig_zero = 1'b0;
      endcase
      case (cfg[`PAG_CFG_T1_SEL])
         3'h0, 3'h1, 3'h2:
            trig_one = i_fault_event[cfg[8:7]];
         3'h3: trig_one = i_sync_source[0];
         3'h4: trig_one = i_sync_source[1];
         3'h5: trig_one = i_sync_source[2];
         default: trig_one = 1'b0;
      endcase
   end

   // ==================================================
   // direction-qualified events
   assign cmp_a = (i_timer_count == stamp_a) &&
                  (stamp_a <= i_timer_period);
   assign cmp_b = (i_timer_count == stamp_b) &&
                  (stamp_b <= i_timer_period);

   always @* begin
      ev = 12'h000;
      ev[`PAG_EV_UZ] = up & i_zero_match;
      ev[`PAG_EV_UP] = up & i_period_match;
      ev[`PAG_EV_UA] = up & cmp_a;
      ev[`PAG_EV_UB] = up & cmp_b;
      ev[`PAG_EV_UT0] = up & trig_zero;
      ev[`PAG_EV_UT1] = up & trig_one;
      ev[`PAG_EV_DZ] = ~up & i_zero_match;
      ev[`PAG_EV_DP] = ~up & i_period_match;
      ev[`PAG_EV_DA] = ~up & cmp_a;
      ev[`PAG_EV_DB] = ~up & cmp_b;
      ev[`PAG_EV_DT0] = ~up & trig_zero;
      ev[`PAG_EV_DT1] = ~up & trig_one;
   end

   // ==================================================
   // per-output resolution
   pag_action u_res_a (
      .i_ev(ev),
      .i_act(act_a),
      .i_force(os_go_a),
      .i_force_act(force_cfg[`PAG_F_OS_A]),
      .i_level(level_a),
      .o_next(next_level_a)
   );
   pag_action u_res_b (
      .i_ev(ev),
      .i_act(act_b),
      .i_force(os_go_b),
      .i_force_act(force_cfg[`PAG_F_OS_B]),
      .i_level(level_b),
      .o_next(next_level_b)
   );

   // ==================================================
   // sustained force engage moment and level
   always @* begin
      case (force_cfg[`PAG_F_SU_TRIG])
         2'h0: su_trig = 1'b1;
         2'h1: su_trig = i_zero_match;
         2'h2: su_trig = i_period_match;
         default: su_trig = i_sync_event;
      endcase
      case (force_cfg[`PAG_F_SU_A])
         `PAG_ACT_LOW: next_su_val_a = 1'b0;
         `PAG_ACT_HIGH: next_su_val_a = 1'b1;
         `PAG_ACT_TOGGLE: next_su_val_a = ~o_output_a;
         default: next_su_val_a = o_output_a;
      endcase
      case (force_cfg[`PAG_F_SU_B])
         `PAG_ACT_LOW: next_su_val_b = 1'b0;
         `PAG_ACT_HIGH: next_su_val_b = 1'b1;
         `PAG_ACT_TOGGLE: next_su_val_b = ~o_output_b;
         default: next_su_val_b = o_output_b;
      endcase
   end

   // ==================================================
   // generator state and outputs
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         level_a <= 1'b0;
         level_b <= 1'b0;
         su_on_a <= 1'b0;
         su_on_b <= 1'b0;
         su_val_a <= 1'b0;
         su_val_b <= 1'b0;
         o_output_a <= 1'b0;
         o_output_b <= 1'b0;
         o_events <= 12'h000;
      end else begin
         level_a <= next_level_a;
         level_b <= next_level_b;
         o_events <= ev;
         if (force_cfg[`PAG_F_SU_A] == `PAG_ACT_NONE) begin
            su_on_a <= 1'b0;
         end else if (!su_on_a && su_trig) begin
            su_on_a <= 1'b1;
            su_val_a <= next_su_val_a;
         end
         if (force_cfg[`PAG_F_SU_B] == `PAG_ACT_NONE) begin
            su_on_b <= 1'b0;
         end else if (!su_on_b && su_trig) begin
            su_on_b <= 1'b1;
            su_val_b <= next_su_val_b;
         end
         o_output_a <= su_on_a ? su_val_a : next_level_a;
         o_output_b <= su_on_b ? su_val_b : next_level_b;
      end
   end

   // ==================================================
   // apb register writes
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         cfg <= `PAG_CFG_RESET;
         force_cfg <= 12'h000;
         os_go_a <= 1'b0;
         os_go_b <= 1'b0;
         ev_flag <= 12'h000;
      end else begin
         os_go_a <= 1'b0;
         os_go_b <= 1'b0;
         if (wr_en && i_paddr == `PAG_OFS_CONFIG) begin
            cfg <= i_pwdata[9:0];
         end
         if (wr_en && i_paddr == `PAG_OFS_FORCE) begin
            force_cfg <= i_pwdata[11:0];
            os_go_a <= i_pwdata[`PAG_F_OS_A_GO];
            os_go_b <= i_pwdata[`PAG_F_OS_B_GO];
         end
         // a new event wins over a write-one clear
         if (wr_en && i_paddr == `PAG_OFS_STATUS) begin
            ev_flag <= (ev_flag & ~i_pwdata[15:4]) | ev;
         end else begin
            ev_flag <= ev_flag | ev;
         end
      end
   end

   // ==================================================
   // apb read mux
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (i_paddr)
         `PAG_OFS_STAMP_A: rd_mux[15:0] = stamp_a_sh;
         `PAG_OFS_STAMP_B: rd_mux[15:0] = stamp_b_sh;
         `PAG_OFS_CONFIG: rd_mux[9:0] = cfg;
         `PAG_OFS_ACT_A: rd_mux[23:0] = act_a_sh;
         `PAG_OFS_ACT_B: rd_mux[23:0] = act_b_sh;
         `PAG_OFS_FORCE: rd_mux[11:0] = force_cfg & 12'hFCF;
         `PAG_OFS_STATUS:
            rd_mux[15:0] = {ev_flag, su_on_b, su_on_a,
                            o_output_b, o_output_a};
         default: rd_err = 1'b1;
      endcase
   end

   // ==================================================
   // apb answer, ready registered in the setup cycle, no wait state
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel & ~i_penable;
         if (i_psel && !i_penable) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
            o_pslverr <= rd_err;
         end else if (!i_psel) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
         end
      end
   end
endmodule // pag_top
`default_nettype wire
